// *** include/mbt_pkg.sv ***
package mbt_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_STROBE_TIMING = 8'h00;
    localparam logic [7:0] ADDR_DRAM_CTRL     = 8'h04;
    localparam logic [7:0] ADDR_STATUS        = 8'h08;
    localparam logic [15:0] STROBE_TIMING_RESET = 16'h0000;
    localparam logic [15:0] DRAM_CTRL_RESET     = 16'h0000;
    localparam logic [15:0] STROBE_WRITE_MASK   = 16'h3BFF;
    // static area timing field positions
    localparam int A4_SETUP_LSB = 11;
    localparam int A4_HOLD_LSB  = 8;
    // dram control field positions
    localparam int TRP0_BIT = 15;
    localparam int RCD0_BIT = 14;
    localparam int TRWL0_BIT = 13;
    localparam int TRAS1_BIT = 12;
    localparam int TRAS0_BIT = 11;
    localparam int BURST_BIT = 10;
    localparam int BANK_ACTIVE_BIT = 9;
    localparam int TRWL1_BIT = 8;
    localparam int AMX2_BIT = 7;
    localparam int WIDTH_BIT = 6;
    localparam int AMX1_BIT = 5;
    localparam int AMX0_BIT = 4;
    localparam int REFRESH_BIT = 3;
    localparam int SELF_REFRESH_BIT = 2;
    localparam int TRP1_BIT = 1;
    localparam int RCD1_BIT = 0;
    localparam logic [2:0] AREA_BANK_ACTIVE = 3'h3;
    localparam logic [2:0] AREA_FOUR        = 3'h4;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] COUNT_ZERO  = 4'h0;
endpackage

// *** hdl/mbt_timing_cfg.sv ***
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - area 4 strobe setup 0.5,1.5,3.5,5.5,7.5 cycles from 3-bit code
// - area 4 address hold 0.5..5.5 cycles, select held 0,1,3,5 cycles
// - areas 0-3 setup and hold 0.5,1.5,2.5 cycles, select hold 0,1,2
// - static timing bits 15, 14, 10 read zero; software writes zero
// - precharge time 1 or 2 cycles before next activation
// - row to column delay 1, 2 or 3 cycles
// - auto-precharge write recovery counted into next activation holdoff
// - bank-active write to precharge 1..3 cycles; synchronous DRAM only
// - DRAM refresh row strobe width 2 to 5 cycles
// - after auto-refresh, activation withheld 3,4,6 or 9 cycles
// - after self-refresh exit, no command for 3,4,6 or 9 cycles, as after auto-refresh
// - burst enable off disables bursting except for synchronous DRAM; on gives page mode
// - burst: 16-bit bus longword/fill/DMA16; 32-bit bus fill/DMA16
// - synchronous DRAM accesses always burst
// - bank-active mode only for area 3; otherwise auto-precharge
module mbt_timing_cfg (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [2:0]  accArea,
    input  wire logic        accSdram,
    input  wire logic        accLongword,
    input  wire logic        accCacheFill,
    input  wire logic        accDma16,
    input  wire logic        prechargeStart,
    input  wire logic        autoRefreshCmd,
    input  wire logic        writeCmdDone,
    input  wire logic        selfRefreshExit,
    output logic [2:0]       setupCycles,
    output logic [2:0]       holdCycles,
    output logic [2:0]       csHoldCycles,
    output logic             strobeOppositePhase,
    output logic             burstOn,
    output logic             autoPrecharge,
    output logic [1:0]       prechargeCycles,
    output logic [1:0]       rowColCycles,
    output logic [1:0]       writeRecCycles,
    output logic [2:0]       rasRefreshWidth,
    output logic             activateBlocked,
    output logic             commandInhibit,
    output logic [2:0]       addressMultiplexSel,
    output logic             memoryWidthSel,
    output logic             refreshOn,
    output logic             selfRefreshSel
);
    logic        awHeld;
    logic        wHeld;
    logic [7:0]  wrAddr;
    logic [15:0] wrData;
    logic [1:0]  wrStrb;
    logic [15:0] strobeTiming;
    logic [15:0] dramCtrl;
    logic        next_awHeld;
    logic        next_wHeld;
    logic [7:0]  next_wrAddr;
    logic [15:0] next_wrData;
    logic [1:0]  next_wrStrb;
    logic [15:0] next_strobeTiming;
    logic [15:0] next_dramCtrl;
    logic        next_awReady;
    logic        next_wReady;
    logic        next_bValid;
    logic [1:0]  next_bResp;
    logic        next_arReady;
    logic        next_rValid;
    logic [31:0] next_rData;
    logic [1:0]  next_rResp;
    logic [15:0] mergedData;
    logic [3:0]  actCount;
    logic [3:0]  inhibitCount;
    logic [3:0]  next_actCount;
    logic [3:0]  next_inhibitCount;
    logic [3:0]  refRecovery;
    logic [3:0]  preLoad;
    logic [3:0]  wrLoad;
    logic [1:0]  trpCode;
    logic [1:0]  rcdCode;
    logic [1:0]  trwlCode;
    logic [1:0]  trasCode;
    logic [2:0]  next_setup;
    logic [2:0]  next_hold;
    logic [2:0]  next_csHold;
    logic        next_burst;
    logic        next_autoPre;
    logic [1:0]  areaCode;

    // bus slave: address and data taken in either order, answer after both
    always_comb
    begin
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_wrAddr = wrAddr;
        next_wrData = wrData;
        next_wrStrb = wrStrb;
        next_strobeTiming = strobeTiming;
        next_dramCtrl = dramCtrl;
        next_bValid = s_axi_bvalid & ~s_axi_bready;
        next_bResp = s_axi_bresp;
        next_rValid = s_axi_rvalid & ~s_axi_rready;
        next_rData = s_axi_rdata;
        next_rResp = s_axi_rresp;
        mergedData = 16'h0000;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_awHeld = 1'b1;
            next_wrAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_wHeld = 1'b1;
            next_wrData = s_axi_wdata[15:0];
            next_wrStrb = s_axi_wstrb[1:0];
        end
        if (awHeld && wHeld && !s_axi_bvalid)
        begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bValid = 1'b1;
            next_bResp = mbt_pkg::RESP_OKAY;
            unique case (wrAddr)
                mbt_pkg::ADDR_STROBE_TIMING:
                begin
                    mergedData[15:8] = wrStrb[1] ? wrData[15:8] : strobeTiming[15:8];
                    mergedData[7:0] = wrStrb[0] ? wrData[7:0] : strobeTiming[7:0];
                    next_strobeTiming = mergedData & mbt_pkg::STROBE_WRITE_MASK;
                end
                mbt_pkg::ADDR_DRAM_CTRL:
                begin
                    mergedData[15:8] = wrStrb[1] ? wrData[15:8] : dramCtrl[15:8];
                    mergedData[7:0] = wrStrb[0] ? wrData[7:0] : dramCtrl[7:0];
                    next_dramCtrl = mergedData;
                end
                mbt_pkg::ADDR_STATUS:
                    next_bResp = mbt_pkg::RESP_SLVERR;
                default:
                    next_bResp = mbt_pkg::RESP_SLVERR;
            endcase
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rValid = 1'b1;
            next_rResp = mbt_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                mbt_pkg::ADDR_STROBE_TIMING:
                    next_rData = {16'h0000, strobeTiming};
                mbt_pkg::ADDR_DRAM_CTRL:
                    next_rData = {16'h0000, dramCtrl};
                mbt_pkg::ADDR_STATUS:
                    next_rData = {22'h0, commandInhibit, activateBlocked,
                                  inhibitCount, actCount};
                default:
                begin
                    next_rData = 32'h00000000;
                    next_rResp = mbt_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_awReady = ~next_awHeld & ~(next_awHeld & next_wHeld) & ~next_bValid;
        next_wReady = ~next_wHeld & ~next_bValid;
        next_arReady = ~next_rValid;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            wrAddr <= 8'h00;
            wrData <= 16'h0000;
            wrStrb <= 2'h0;
            strobeTiming <= mbt_pkg::STROBE_TIMING_RESET;
            dramCtrl <= mbt_pkg::DRAM_CTRL_RESET;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= mbt_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= mbt_pkg::RESP_OKAY;
        end
        else
        begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            wrAddr <= next_wrAddr;
            wrData <= next_wrData;
            wrStrb <= next_wrStrb;
            strobeTiming <= next_strobeTiming;
            dramCtrl <= next_dramCtrl;
            s_axi_awready <= next_awReady;
            s_axi_wready <= next_wReady;
            s_axi_bvalid <= next_bValid;
            s_axi_bresp <= next_bResp;
            s_axi_arready <= next_arReady;
            s_axi_rvalid <= next_rValid;
            s_axi_rdata <= next_rData;
            s_axi_rresp <= next_rResp;
        end
    end

    // timing decode and activation holdoff
    always_comb
    begin
        trpCode = {dramCtrl[mbt_pkg::TRP1_BIT], dramCtrl[mbt_pkg::TRP0_BIT]};
        rcdCode = {dramCtrl[mbt_pkg::RCD1_BIT], dramCtrl[mbt_pkg::RCD0_BIT]};
        trwlCode = {dramCtrl[mbt_pkg::TRWL1_BIT], dramCtrl[mbt_pkg::TRWL0_BIT]};
        trasCode = {dramCtrl[mbt_pkg::TRAS1_BIT], dramCtrl[mbt_pkg::TRAS0_BIT]};
        areaCode = 2'h0;
        next_setup = 3'h0;
        next_hold = 3'h0;
        if (accArea == mbt_pkg::AREA_FOUR)
        begin
            unique case (strobeTiming[mbt_pkg::A4_SETUP_LSB +: 3])
                3'h1: next_setup = 3'h1;
                3'h2: next_setup = 3'h3;
                3'h3: next_setup = 3'h5;
                3'h4: next_setup = 3'h7;
                default: next_setup = 3'h0;
            endcase
            unique case (strobeTiming[mbt_pkg::A4_HOLD_LSB +: 2])
                2'h0: next_hold = 3'h0;
                2'h1: next_hold = 3'h1;
                2'h2: next_hold = 3'h3;
                2'h3: next_hold = 3'h5;
            endcase
        end
        else if (accArea < mbt_pkg::AREA_FOUR)
        begin
            areaCode = strobeTiming[{accArea[1:0], 1'b0} +: 2];
            next_setup = {1'b0, areaCode};
            next_hold = {1'b0, areaCode};
        end
        // cs hold equals whole cycles of address hold
        next_csHold = next_hold;
        if (accSdram)
            next_burst = 1'b1;
        else if (!dramCtrl[mbt_pkg::BURST_BIT])
            next_burst = 1'b0;
        else if (dramCtrl[mbt_pkg::WIDTH_BIT])
            next_burst = accCacheFill | accDma16;
        else
            next_burst = accLongword | accCacheFill | accDma16;
        next_autoPre = accSdram & ~(dramCtrl[mbt_pkg::BANK_ACTIVE_BIT] &
                       (accArea == mbt_pkg::AREA_BANK_ACTIVE));
        unique case (trasCode)
            2'h0: refRecovery = 4'h3;
            2'h1: refRecovery = 4'h4;
            2'h2: refRecovery = 4'h6;
            2'h3: refRecovery = 4'h9;
        endcase
        preLoad = {3'h0, trpCode[0]} + 4'h1;
        wrLoad = {2'h0, trwlCode} + 4'h1 + preLoad;
        next_actCount = (actCount != mbt_pkg::COUNT_ZERO) ? actCount - 4'h1 : actCount;
        if (prechargeStart && preLoad > next_actCount)
            next_actCount = preLoad;
        if (writeCmdDone && next_autoPre && wrLoad > next_actCount)
            next_actCount = wrLoad;
        if (autoRefreshCmd)
            next_actCount = refRecovery;
        next_inhibitCount = (inhibitCount != mbt_pkg::COUNT_ZERO) ?
                            inhibitCount - 4'h1 : inhibitCount;
        if (selfRefreshExit)
            next_inhibitCount = refRecovery;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            actCount <= mbt_pkg::COUNT_ZERO;
            inhibitCount <= mbt_pkg::COUNT_ZERO;
            setupCycles <= 3'h0;
            holdCycles <= 3'h0;
            csHoldCycles <= 3'h0;
            strobeOppositePhase <= 1'b0;
            burstOn <= 1'b0;
            autoPrecharge <= 1'b0;
            prechargeCycles <= 2'h1;
            rowColCycles <= 2'h1;
            writeRecCycles <= 2'h1;
            rasRefreshWidth <= 3'h2;
            activateBlocked <= 1'b0;
            commandInhibit <= 1'b0;
            addressMultiplexSel <= 3'h0;
            memoryWidthSel <= 1'b0;
            refreshOn <= 1'b0;
            selfRefreshSel <= 1'b0;
        end
        else
        begin
            actCount <= next_actCount;
            inhibitCount <= next_inhibitCount;
            setupCycles <= next_setup;
            holdCycles <= next_hold;
            csHoldCycles <= next_csHold;
            strobeOppositePhase <= ~accSdram;
            burstOn <= next_burst;
            autoPrecharge <= next_autoPre;
            prechargeCycles <= {1'b0, trpCode[0]} + 2'h1;
            rowColCycles <= rcdCode + 2'h1;
            // zero for anything but synchronous DRAM
            writeRecCycles <= accSdram ? trwlCode + 2'h1 : 2'h0;
            rasRefreshWidth <= {1'b0, trasCode} + 3'h2;
            activateBlocked <= next_actCount != mbt_pkg::COUNT_ZERO;
            commandInhibit <= next_inhibitCount != mbt_pkg::COUNT_ZERO;
            addressMultiplexSel <= {dramCtrl[mbt_pkg::AMX2_BIT],
                                    dramCtrl[mbt_pkg::AMX1_BIT], dramCtrl[mbt_pkg::AMX0_BIT]};
            memoryWidthSel <= dramCtrl[mbt_pkg::WIDTH_BIT];
            refreshOn <= dramCtrl[mbt_pkg::REFRESH_BIT];
            selfRefreshSel <= dramCtrl[mbt_pkg::SELF_REFRESH_BIT];
        end
    end
endmodule

// *** sim/mbt_event_model.sv ***
`timescale 1ns/1ps
module mbt_event_model (
    input  wire logic       clock,
    input  wire logic [3:0] fire,
    output logic            prechargeStart,
    output logic            autoRefreshCmd,
    output logic            writeCmdDone,
    output logic            selfRefreshExit
);
    // one-cycle command pulses, one edge after each request
    always_ff @(posedge clock)
    begin
        {selfRefreshExit, writeCmdDone, autoRefreshCmd, prechargeStart} <= fire;
    end
endmodule

// *** sim/mbt_timing_cfg_monitor.sv ***
`timescale 1ns/1ps
module mbt_timing_cfg_monitor (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic [2:0] accArea,
    input wire logic       accSdram,
    input wire logic       prechargeStart,
    input wire logic       autoRefreshCmd,
    input wire logic       writeCmdDone,
    input wire logic       selfRefreshExit,
    input wire logic [2:0] setupCycles,
    input wire logic [2:0] holdCycles,
    input wire logic [2:0] csHoldCycles,
    input wire logic       burstOn,
    input wire logic       autoPrecharge,
    input wire logic [1:0] writeRecCycles,
    input wire logic [2:0] rasRefreshWidth,
    input wire logic       activateBlocked,
    input wire logic       commandInhibit
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_low_equal:
        assert property (accArea < 3'h4 |=> setupCycles == holdCycles
            && holdCycles == csHoldCycles) else $error("low area timing differs");
    a_area4_hold:
        assert property (accArea == 3'h4 |=> holdCycles == csHoldCycles
            && holdCycles inside {3'h0, 3'h1, 3'h3, 3'h5}) else $error("area 4 hold wrong");
    a_sdram_burst:
        assert property (rst_n && accSdram |=> burstOn) else $error("sdram access not burst");
    a_auto_pre:
        assert property (rst_n && accSdram && accArea != 3'h3 |=> autoPrecharge)
        else $error("auto-precharge missing");
    a_wrec_zero:
        assert property (rst_n && !accSdram |=> writeRecCycles == 2'h0)
        else $error("write recovery used");
    a_ras_range:
        assert property (rasRefreshWidth >= 3'h2 && rasRefreshWidth <= 3'h5)
        else $error("refresh width out of range");
    a_refresh_min:
        assert property (autoRefreshCmd |=> activateBlocked [*3]) else $error("holdoff short");
    a_refresh_exact:
        assert property (autoRefreshCmd && rasRefreshWidth == 3'h2 && !prechargeStart
            && !writeCmdDone |=> activateBlocked [*3] ##1 !activateBlocked)
        else $error("holdoff length wrong");
    a_exit_inhibit:
        assert property (selfRefreshExit |=> commandInhibit [*3]) else $error("inhibit short");
    a_pre_block:
        assert property (prechargeStart |=> activateBlocked) else $error("precharge not held");
endmodule
bind mbt_timing_cfg mbt_timing_cfg_monitor u_mon (
    .clock           (clock),
    .rst_n           (rst_n),
    .accArea         (accArea),
    .accSdram        (accSdram),
    .prechargeStart  (prechargeStart),
    .autoRefreshCmd  (autoRefreshCmd),
    .writeCmdDone    (writeCmdDone),
    .selfRefreshExit (selfRefreshExit),
    .setupCycles     (setupCycles),
    .holdCycles      (holdCycles),
    .csHoldCycles    (csHoldCycles),
    .burstOn         (burstOn),
    .autoPrecharge   (autoPrecharge),
    .writeRecCycles  (writeRecCycles),
    .rasRefreshWidth (rasRefreshWidth),
    .activateBlocked (activateBlocked),
    .commandInhibit  (commandInhibit)
);

// *** sim/test_mbt_timing_cfg.sv ***
`timescale 1ns/1ps
module test_mbt_timing_cfg;
    localparam logic [7:0] ST = mbt_pkg::ADDR_STROBE_TIMING;
    localparam logic [7:0] DC = mbt_pkg::ADDR_DRAM_CTRL;
    localparam logic [1:0] OK = mbt_pkg::RESP_OKAY;
    localparam logic [1:0] SE = mbt_pkg::RESP_SLVERR;
    logic clock = 0, rst_n = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, fire = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, prechargeCycles, rowColCycles, writeRecCycles;
    logic [2:0] accArea = 0, setupCycles, holdCycles, csHoldCycles, rasRefreshWidth;
    logic [2:0] addressMultiplexSel;
    logic accSdram = 0, accLongword = 0, accCacheFill = 0, accDma16 = 0;
    logic prechargeStart, autoRefreshCmd, writeCmdDone, selfRefreshExit;
    logic strobeOppositePhase, burstOn, autoPrecharge, activateBlocked, commandInhibit;
    logic memoryWidthSel, refreshOn, selfRefreshSel;
    int numErrors = 0, compares = 0;
    mbt_timing_cfg uut (
        .clock(clock),
        .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .accArea(accArea),
        .accSdram(accSdram),
        .accLongword(accLongword),
        .accCacheFill(accCacheFill),
        .accDma16(accDma16),
        .prechargeStart(prechargeStart),
        .autoRefreshCmd(autoRefreshCmd),
        .writeCmdDone(writeCmdDone),
        .selfRefreshExit(selfRefreshExit),
        .setupCycles(setupCycles),
        .holdCycles(holdCycles),
        .csHoldCycles(csHoldCycles),
        .strobeOppositePhase(strobeOppositePhase),
        .burstOn(burstOn),
        .autoPrecharge(autoPrecharge),
        .prechargeCycles(prechargeCycles),
        .rowColCycles(rowColCycles),
        .writeRecCycles(writeRecCycles),
        .rasRefreshWidth(rasRefreshWidth),
        .activateBlocked(activateBlocked),
        .commandInhibit(commandInhibit),
        .addressMultiplexSel(addressMultiplexSel),
        .memoryWidthSel(memoryWidthSel),
        .refreshOn(refreshOn),
        .selfRefreshSel(selfRefreshSel)
    );
    mbt_event_model u_model (
        .clock(clock),
        .fire(fire),
        .prechargeStart(prechargeStart),
        .autoRefreshCmd(autoRefreshCmd),
        .writeCmdDone(writeCmdDone),
        .selfRefreshExit(selfRefreshExit)
    );
    always #20 clock = ~clock;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("compares=%0d numErrors=%0d", compares, numErrors);
        if (numErrors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
        @(posedge clock);
    endtask
    // fresh reset, then the control word written once
    task automatic cfg(input logic [31:0] d);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        wr(DC, d, OK);
    endtask
    task automatic see(input logic [2:0] ar, input logic [3:0] at);
        accArea <= ar;
        {accSdram, accLongword, accCacheFill, accDma16} <= at;
        repeat (2) @(posedge clock);
    endtask
    // pulse a command, count cycles the holdoff stays up
    task automatic ev(input logic [3:0] f, input int exp);
        int n;
        n = 0;
        fire <= f;
        @(posedge clock);
        fire <= 4'h0;
        repeat (14)
        begin
            @(posedge clock);
            if ((f[3] ? commandInhibit : activateBlocked) === 1'b1) n++;
        end
        chk(n, exp);
    endtask
    task automatic t_reset;
        rd(ST, 32'h0, OK);
        rd(DC, 32'h0, OK);
        chk(prechargeCycles, 32'h1);
        chk(rowColCycles, 32'h1);
        chk(rasRefreshWidth, 32'h2);
        chk(burstOn, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_static;
        int s4 [5] = '{0, 1, 3, 5, 7};
        int c;
        cfg(32'h0);
        see(3'h4, 4'h0);
        wr(ST, 32'hFFFF, OK);
        rd(ST, 32'h3BFF, OK);
        for (int i = 0; i < 5; i++)
        begin
            wr(ST, 32'(i) << 11 | 32'(i % 4) << 8, OK);
            see(3'h4, 4'h0);
            chk(setupCycles, s4[i]);
            chk(holdCycles, s4[i % 4]);
            chk(csHoldCycles, s4[i % 4]);
            chk(strobeOppositePhase, 32'h1);
        end
        for (int k = 0; k < 3; k++)
        begin
            wr(ST, 32'(k) | 32'((k + 1) % 3) << 2 | 32'((k + 2) % 3) << 4 | 32'(k) << 6, OK);
            for (int a = 0; a < 4; a++)
            begin
                c = (k + a) % 3;
                see(3'(a), 4'h0);
                chk(setupCycles, c);
                chk(csHoldCycles, c);
            end
        end
        $display("test static done");
    endtask
    task automatic t_dram;
        int tr [4] = '{3, 4, 6, 9};
        int p, r, w;
        logic [31:0] d;
        for (int i = 0; i < 4; i++)
        begin
            p = i % 2;
            r = i % 3;
            w = (i + 1) % 3;
            d = 32'(p) << 15 | 32'(r % 2) << 14 | 32'(r / 2) | 32'(w % 2) << 13
                | 32'(w / 2) << 8 | 32'(i) << 11;
            cfg(d);
            rd(DC, d, OK);
            see(3'h3, 4'h8);
            chk(prechargeCycles, p + 1);
            chk(rowColCycles, r + 1);
            chk(writeRecCycles, w + 1);
            chk(rasRefreshWidth, i + 2);
            ev(4'h1, p + 1);
            ev(4'h4, w + p + 2);
            ev(4'h2, tr[i]);
            ev(4'h8, tr[i]);
        end
        $display("test dram done");
    endtask
    task automatic t_burst;
        logic [5:0] cs [6] = '{6'h0E, 6'h29, 6'h38, 6'h35, 6'h33, 6'h20};
        for (int i = 0; i < 6; i++)
        begin
            cfg(32'(cs[i][5]) << 10 | 32'(cs[i][4]) << 6);
            see(3'h2, {1'b0, cs[i][3:1]});
            chk(burstOn, cs[i][0]);
            chk(memoryWidthSel, cs[i][4]);
        end
        cfg(32'h0);
        see(3'h2, 4'h8);
        chk(burstOn, 32'h1);
        cfg(32'h200);
        see(3'h3, 4'h8);
        chk(autoPrecharge, 32'h0);
        see(3'h2, 4'h8);
        chk(autoPrecharge, 32'h1);
        rd(8'h0C, 32'h0, SE);
        wr(8'h0C, 32'h1, SE);
        cfg(32'hBC);
        see(3'h0, 4'h0);
        chk(addressMultiplexSel, 32'h7);
        chk({refreshOn, selfRefreshSel}, 32'h3);
        rd(mbt_pkg::ADDR_STATUS, 32'h0, OK);
        wr(mbt_pkg::ADDR_STATUS, 32'h1, SE);
        $display("test burst done");
    endtask
    initial
    begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_reset;
        t_static;
        t_dram;
        t_burst;
        summarize;
    end
    initial
    begin
        #400000;
        numErrors++;
        summarize;
    end
endmodule
